// >>> common/dfv_pkg.sv
// constants and types for the format, verify and diagnostics command block
// assumes a 100 MHz system clock and one register word per 32-bit bus slot
// What this block does
// - format opcode writes the addressed track
// - entry byte one: good, bad, unassign, assign
// - entry byte two is sector id 1..SECTORS_PER_TRACK
// - missing or invalid entry: sector skipped
// - formatted data fields are all zero
// - SECTORS_PER_TRACK from count, only 512-byte size
// - interrupt when format completes
// - verify reads like read, no host data
// - verify checks active cache segment first; the code tests cache_part_chg_i before it and seeks on a change
// - valid cylinder miss starts disk read
// - invalid cylinder: search other segments, then seek
// - diagnostics code placed in error register
// - self-tests: ROM, registers, RAM patterns
// - master samples passed-diagnostics line
// - slave pulls line low on passing
// - diagnostics run whichever drive selected
// - master drives bus, waits bounded time
// - drive-select bit reads zero afterwards
// - sector count zero means 256
package dfv_pkg;
    // timing
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned DIAG_WAIT_MS  = 5000;
    localparam int unsigned DIAG_WAIT_CYC = DIAG_WAIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned WAIT_W        = 29;
    // register byte offsets
    localparam logic [7:0] OFS_ERROR  = 8'h00;
    localparam logic [7:0] OFS_SECCNT = 8'h04;
    localparam logic [7:0] OFS_SECNUM = 8'h08;
    localparam logic [7:0] OFS_CYL_LO = 8'h0C;
    localparam logic [7:0] OFS_CYL_HI = 8'h10;
    localparam logic [7:0] OFS_SDH    = 8'h14;
    localparam logic [7:0] OFS_CMD    = 8'h18;
    localparam logic [7:0] OFS_TBLIDX = 8'h20;
    localparam logic [7:0] OFS_TBLDAT = 8'h24;
    // opcodes
    localparam logic [7:0] OP_FORMAT = 8'h50;
    localparam logic [7:0] OP_VERIFY = 8'h40;
    localparam logic [7:0] OP_DIAG   = 8'h90;
    // interleave entry flags
    localparam logic [7:0] FLG_GOOD     = 8'h00;
    localparam logic [7:0] FLG_BAD      = 8'h80;
    localparam logic [7:0] FLG_UNASSIGN = 8'h20;
    localparam logic [7:0] FLG_ASSIGN   = 8'h40;
    // error register values
    localparam logic [7:0] DG_OK     = 8'h01;
    localparam logic [7:0] DG_SLAVE  = 8'h80;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] ERR_UNC   = 8'h40;
    localparam logic [7:0] RST_ERR   = 8'h00;
    localparam logic [7:0] RST_TF    = 8'h00;
    // field positions
    localparam int unsigned SDH_DRV_BIT  = 4;
    localparam int unsigned SDH_SIZE_LSB = 5;
    localparam logic [1:0]  SIZE_512     = 2'b01;
    localparam int unsigned ST_BSY       = 7;
    localparam int unsigned ST_DRDY      = 6;
    localparam int unsigned ST_ERR       = 0;
    localparam logic [7:0]  ZERO_FILL    = 8'h00;
    localparam logic [7:0]  LAST_ENTRY   = 8'hFF;
    localparam int unsigned TBL_DEPTH    = 256;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_DECERR  = 2'b11;

    typedef enum logic [1:0] {FK_GOOD, FK_BAD, FK_UNASSIGN, FK_ASSIGN} dfv_kind_t;
endpackage

// >>> logic/dfv_tbl_mem.sv
// interleave table store: 256 entries of two bytes each
// assumes writer and reader share the system clock
`timescale 1ns/1ns
module dfv_tbl_mem
    import dfv_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // write port
    input  wire logic        we_i,
    input  wire logic [7:0]  waddr_i,
    input  wire logic [15:0] wdata_i,
    // read port, data one cycle later
    input  wire logic [7:0]  raddr_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem_q [TBL_DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule

// >>> logic/dfv_cmd_core.sv
// command engine for format track, read verify and execute diagnostics
// assumes cache, disk, self-test and format sides run on clk_i;
// strap pins and the open-drain diagnostics line are asynchronous
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
module dfv_cmd_core
    import dfv_pkg::*;
#(
    parameter int unsigned DIAG_WAIT = dfv_pkg::DIAG_WAIT_CYC
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // host interrupt and drive pins
    output logic             intrq_o,
    input  wire logic        master_cfg_i,
    input  wire logic        slave_fitted_i,
    input  wire logic        passed_diag_line_i,
    output logic             passed_diag_line_o,
    output logic             passed_diag_line_oe_n_o,
    // format sector stream
    output logic             fmt_valid_o,
    input  wire logic        fmt_ready_i,
    output logic [7:0]       fmt_sec_id_o,
    output dfv_pkg::dfv_kind_t fmt_kind_o,
    output logic [15:0]      fmt_cyl_o,
    output logic [3:0]       fmt_head_o,
    output logic [7:0]       fmt_fill_o,
    // cache lookup results
    input  wire logic        cache_part_chg_i,
    input  wire logic        cache_act_hit_i,
    input  wire logic        cache_cyl_valid_i,
    input  wire logic        cache_oth_hit_i,
    // seek and disk read
    output logic             seek_req_o,
    input  wire logic        seek_done_i,
    output logic             rd_req_o,
    output logic [8:0]       rd_count_o,
    output logic             rd_no_retry_o,
    input  wire logic        rd_done_i,
    input  wire logic        rd_err_i,
    // self-test engine
    output logic             st_start_o,
    input  wire logic        st_done_i,
    input  wire logic [7:0]  st_code_i
);
    import dfv_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_FMT_RD, S_FMT_CHK, S_FMT_OUT, S_RV_LOOK, S_RV_OTHER,
        S_RV_SEEK, S_RV_READ, S_DG_TEST, S_DG_WAIT, S_DONE
    } dfv_state_t;

    typedef struct packed {
        logic              aw_have;
        logic [7:0]        aw_addr;
        logic              w_have;
        logic [31:0]       w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [7:0]        err;
        logic [7:0]        seccnt;
        logic [7:0]        secnum;
        logic [7:0]        cyl_lo;
        logic [7:0]        cyl_hi;
        logic [7:0]        drive_head_select_reg;
        logic [7:0]        cmd;
        logic              bsy;
        logic              intrq;
        logic [7:0]        tbl_idx;
        dfv_state_t        st;
        logic [7:0]        idx;
        logic [15:0]       ent;
        logic [WAIT_W-1:0] cnt;
        logic [7:0]        own;
        logic              pd_drive;
        logic              mst_s1;
        logic              mst_s2;
        logic              sfit_s1;
        logic              sfit_s2;
        logic              pd_s1;
        logic              pd_s2;
        logic              st_start;
        logic              rd_req;
        logic              seek_req;
        logic              fmt_valid;
    } dfv_core_t;

    dfv_core_t   q;
    dfv_core_t   d;
    logic        mem_we;
    logic [15:0] mem_rdata;
    logic [8:0]  sectors_per_track;

    function automatic logic f_mapped(input logic [7:0] a);
        return a inside {OFS_ERROR, OFS_SECCNT, OFS_SECNUM, OFS_CYL_LO, OFS_CYL_HI,
                         OFS_SDH, OFS_CMD, OFS_TBLIDX, OFS_TBLDAT};
    endfunction

    function automatic logic f_flag_ok(input logic [7:0] f);
        return f inside {FLG_GOOD, FLG_BAD, FLG_UNASSIGN, FLG_ASSIGN};
    endfunction

    function automatic dfv_kind_t f_kind(input logic [7:0] f);
        unique case (f)
            FLG_BAD:      return FK_BAD;
            FLG_UNASSIGN: return FK_UNASSIGN;
            FLG_ASSIGN:   return FK_ASSIGN;
            default:      return FK_GOOD;
        endcase
    endfunction

    assign sectors_per_track = {(q.seccnt == 8'h00), q.seccnt};

    dfv_tbl_mem u_tbl (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (q.tbl_idx),
        .wdata_i (q.w_data[15:0]),
        .raddr_i (q.idx),
        .rdata_o (mem_rdata)
    );

    always_comb
    begin
        d          = q;
        mem_we     = 1'b0;
        d.st_start = 1'b0;
        d.rd_req   = 1'b0;
        d.seek_req = 1'b0;
        d.mst_s1   = master_cfg_i;
        d.mst_s2   = q.mst_s1;
        d.sfit_s1  = slave_fitted_i;
        d.sfit_s2  = q.sfit_s1;
        d.pd_s1    = passed_diag_line_i;
        d.pd_s2    = q.pd_s1;
        // bus: address and data taken in either order
        if (s_axi_awvalid && !q.aw_have)
        begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_have)
        begin
            d.w_have  = 1'b1;
            d.w_data  = s_axi_wdata;
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid)
        begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = f_mapped(q.aw_addr) ? RESP_OKAY : RESP_DECERR;
            if (q.w_lane0)
            begin
                unique case (q.aw_addr)
                    OFS_SECCNT: if (!q.bsy) d.seccnt = q.w_data[7:0];
                    OFS_SECNUM: if (!q.bsy) d.secnum = q.w_data[7:0];
                    OFS_CYL_LO: if (!q.bsy) d.cyl_lo = q.w_data[7:0];
                    OFS_CYL_HI: if (!q.bsy) d.cyl_hi = q.w_data[7:0];
                    OFS_SDH:    if (!q.bsy) d.drive_head_select_reg = q.w_data[7:0];
                    OFS_TBLIDX: d.tbl_idx = q.w_data[7:0];
                    OFS_TBLDAT:
                    begin
                        mem_we    = 1'b1;
                        d.tbl_idx = q.tbl_idx + 8'h01;
                    end
                    OFS_CMD:
                    if (!q.bsy && (q.w_data[7:0] == OP_DIAG
                                   || q.drive_head_select_reg[SDH_DRV_BIT] == !q.mst_s2))
                    begin
                        d.cmd   = q.w_data[7:0];
                        d.bsy   = 1'b1;
                        d.intrq = 1'b0;
                        d.err   = RST_ERR;
                        d.idx   = 8'h00;
                        if (q.w_data[7:0] == OP_FORMAT)
                        begin
                            if (q.drive_head_select_reg[SDH_SIZE_LSB +: 2] == SIZE_512)
                                d.st = S_FMT_RD;
                            else
                            begin
                                d.err = ERR_ABORT;
                                d.st  = S_DONE;
                            end
                        end
                        else if (q.w_data[7:1] == OP_VERIFY[7:1])
                            d.st = S_RV_LOOK;
                        else if (q.w_data[7:0] == OP_DIAG)
                        begin
                            d.st_start = 1'b1;
                            d.pd_drive = 1'b0;
                            d.st       = S_DG_TEST;
                        end
                        else
                        begin
                            d.err = ERR_ABORT;
                            d.st  = S_DONE;
                        end
                    end
                    default: ;
                endcase
            end
        end
        // bus reads; status read drops the interrupt
        if (s_axi_rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid)
        begin
            d.rvalid = 1'b1;
            d.rresp  = f_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
            d.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                OFS_ERROR:  d.rdata[7:0] = q.err;
                OFS_SECCNT: d.rdata[7:0] = q.seccnt;
                OFS_SECNUM: d.rdata[7:0] = q.secnum;
                OFS_CYL_LO: d.rdata[7:0] = q.cyl_lo;
                OFS_CYL_HI: d.rdata[7:0] = q.cyl_hi;
                OFS_SDH:    d.rdata[7:0] = q.drive_head_select_reg;
                OFS_TBLIDX: d.rdata[7:0] = q.tbl_idx;
                OFS_CMD:
                begin
                    d.rdata[ST_BSY]  = q.bsy;
                    d.rdata[ST_DRDY] = !q.bsy;
                    d.rdata[ST_ERR]  = (q.cmd == OP_DIAG) ? (q.err != DG_OK)
                                                          : (q.err != RST_ERR);
                    d.intrq = 1'b0;
                end
                default: ;
            endcase
        end
        // command engine
        unique case (q.st)
            S_IDLE: ;
            // walk the table for the addressed track
            S_FMT_RD: d.st = S_FMT_CHK;
            S_FMT_CHK:
            begin
                if (f_flag_ok(mem_rdata[7:0]) && mem_rdata[15:8] != 8'h00
                    && {1'b0, mem_rdata[15:8]} <= sectors_per_track)
                begin
                    d.ent       = mem_rdata;
                    d.fmt_valid = 1'b1;
                    d.st        = S_FMT_OUT;
                end
                else if (q.idx == LAST_ENTRY)
                    d.st = S_DONE;
                else
                begin
                    d.idx = q.idx + 8'h01;
                    d.st  = S_FMT_RD;
                end
            end
            S_FMT_OUT:
            if (fmt_ready_i)
            begin
                d.fmt_valid = 1'b0;
                d.idx       = q.idx + 8'h01;
                d.st        = (q.idx == LAST_ENTRY) ? S_DONE : S_FMT_RD;
            end
            S_RV_LOOK:
            begin
                if (cache_part_chg_i)
                begin
                    d.seek_req = 1'b1;
                    d.st       = S_RV_SEEK;
                end
                else if (cache_act_hit_i)
                    d.st = S_DONE;
                else if (cache_cyl_valid_i)
                begin
                    d.rd_req = 1'b1;
                    d.st     = S_RV_READ;
                end
                else
                    d.st = S_RV_OTHER;
            end
            S_RV_OTHER:
            if (cache_oth_hit_i)
                d.st = S_DONE;
            else
            begin
                d.seek_req = 1'b1;
                d.st       = S_RV_SEEK;
            end
            S_RV_SEEK:
            if (seek_done_i)
            begin
                d.rd_req = 1'b1;
                d.st     = S_RV_READ;
            end
            // read completes with no host transfer
            S_RV_READ:
            if (rd_done_i)
            begin
                d.err = rd_err_i ? ERR_UNC : RST_ERR;
                d.st  = S_DONE;
            end
            S_DG_TEST:
            if (st_done_i)
            begin
                d.own = st_code_i;
                d.err = st_code_i;
                d.st  = S_DONE;
                if (!q.mst_s2)
                    d.pd_drive = (st_code_i == DG_OK);
                else if (q.sfit_s2)
                begin
                    d.cnt = WAIT_W'(DIAG_WAIT);
                    d.st  = S_DG_WAIT;
                end
            end
            S_DG_WAIT:
            begin
                d.cnt = q.cnt - 1'b1;
                if (!q.pd_s2)
                    d.st = S_DONE;
                else if (q.cnt <= 1)
                begin
                    d.err = {DG_SLAVE[7:4], q.own[3:0]};
                    d.st  = S_DONE;
                end
            end
            S_DONE:
            begin
                d.bsy   = 1'b0;
                d.intrq = 1'b1;
                d.st    = S_IDLE;
                if (q.cmd == OP_DIAG)
                    d.drive_head_select_reg[SDH_DRV_BIT] = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            q        <= '0;
            q.err    <= RST_ERR;
            q.seccnt <= RST_TF;
            q.drive_head_select_reg    <= RST_TF;
            q.cmd    <= RST_TF;
            q.st     <= S_IDLE;
            q.pd_s1  <= 1'b1;
            q.pd_s2  <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready           = !q.aw_have;
    assign s_axi_wready            = !q.w_have;
    assign s_axi_bvalid            = q.bvalid;
    assign s_axi_bresp             = q.bresp;
    assign s_axi_arready           = !q.rvalid;
    assign s_axi_rvalid            = q.rvalid;
    assign s_axi_rdata             = q.rdata;
    assign s_axi_rresp             = q.rresp;
    assign intrq_o                 = q.intrq;
    assign passed_diag_line_o      = 1'b0;
    assign passed_diag_line_oe_n_o = !q.pd_drive;
    assign fmt_valid_o             = q.fmt_valid;
    assign fmt_sec_id_o            = q.ent[15:8];
    assign fmt_kind_o              = f_kind(q.ent[7:0]);
    assign fmt_cyl_o               = {q.cyl_hi, q.cyl_lo};
    assign fmt_head_o              = q.drive_head_select_reg[3:0];
    assign fmt_fill_o              = ZERO_FILL;
    assign seek_req_o              = q.seek_req;
    assign rd_req_o                = q.rd_req;
    assign rd_count_o              = sectors_per_track;
    assign rd_no_retry_o           = q.cmd[0];
    assign st_start_o              = q.st_start;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_fmt_id;
        fmt_valid_o |-> fmt_sec_id_o != 8'h00 && {1'b0, fmt_sec_id_o} <= sectors_per_track;
    endproperty
    a_fmt_id: assert property (p_fmt_id) else $error("format id out of range");
    property p_fmt_hold;
        fmt_valid_o && !fmt_ready_i |=> fmt_valid_o && $stable(fmt_sec_id_o);
    endproperty
    a_fmt_hold: assert property (p_fmt_hold) else $error("format sector dropped");
    property p_fmt_size;
        q.st == S_FMT_RD |-> q.drive_head_select_reg[SDH_SIZE_LSB +: 2] == SIZE_512;
    endproperty
    a_fmt_size: assert property (p_fmt_size) else $error("bad size formatted");
    property p_intrq;
        q.st == S_DONE |=> intrq_o && !q.bsy;
    endproperty
    a_intrq: assert property (p_intrq) else $error("no completion interrupt");
    property p_rv_read;
        q.st == S_RV_LOOK && !cache_part_chg_i && !cache_act_hit_i && cache_cyl_valid_i
            |=> rd_req_o ##1 q.st == S_RV_READ;
    endproperty
    a_rv_read: assert property (p_rv_read) else $error("miss did not read");
    property p_rv_seek;
        seek_req_o |-> $past(q.st) inside {S_RV_OTHER, S_RV_LOOK};
    endproperty
    a_rv_seek: assert property (p_rv_seek) else $error("seek out of order");
    property p_count;
        rd_req_o && q.seccnt == 8'h00 |-> rd_count_o == 9'h100;
    endproperty
    a_count: assert property (p_count) else $error("zero count not 256");
    property p_passed_diag_line;
        !passed_diag_line_oe_n_o |-> !q.mst_s2 && q.err == DG_OK;
    endproperty
    a_passed_diag_line: assert property (p_passed_diag_line) else $error("line pulled wrongly");
    property p_timeout;
        q.st == S_DG_WAIT && q.cnt == 1 && q.pd_s2 |=> q.err[7] ##1 intrq_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no slave failure code");
    property p_sdh;
        q.st == S_DONE && q.cmd == OP_DIAG |=> !q.drive_head_select_reg[SDH_DRV_BIT];
    endproperty
    a_sdh: assert property (p_sdh) else $error("drive bit not cleared");

    c_fmt_sec: cover property (fmt_valid_o && fmt_ready_i);
    c_rv_hit:  cover property (q.st == S_RV_OTHER && cache_oth_hit_i);
    c_dg_pass: cover property (q.st == S_DG_WAIT && !q.pd_s2);
    c_dg_tmo:  cover property (q.st == S_DG_WAIT && q.cnt == 1);
endmodule

// >>> sim/dfv_far_model.sv
// far side of the command block: format sink, seek, disk read and self-test
// assumes the block's one-cycle request pulses on the shared clock
`timescale 1ns/1ns
module dfv_far_model
(
    // clock
    input  wire logic clk_i,
    // requests
    input  wire logic fmt_valid_i,
    input  wire logic seek_req_i,
    input  wire logic rd_req_i,
    input  wire logic st_start_i,
    // answers
    output logic      fmt_ready_o = 1'b0,
    output logic      seek_done_o = 1'b0,
    output logic      rd_done_o   = 1'b0,
    output logic      st_done_o   = 1'b0
);
    // sink stalls every other cycle, others answer one cycle late
    always @(posedge clk_i)
    begin
        fmt_ready_o <= fmt_valid_i & ~fmt_ready_o;
        seek_done_o <= seek_req_i;
        rd_done_o   <= rd_req_i;
        st_done_o   <= st_start_i;
    end
endmodule

// >>> sim/tb_disk_format_verify_diag_cmds.sv
// bench for the format, verify and diagnostics command block
// assumes a master drive with a fitted slave, failing first and passing later
`timescale 1ns/1ns
module tb_disk_format_verify_diag_cmds;
    import dfv_pkg::*;
    logic clk_i = 0, arst_n_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, intrq_o, fmt_valid_o, fmt_ready_i, seek_req_o, rd_req_o;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, fmt_sec_id_o, fmt_fill_o;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic cache_act_hit_i = 0, cache_cyl_valid_i = 0, cache_oth_hit_i = 0, line_oe_n, st_go;
    logic cache_part_chg_i = 0, rd_err_i = 0, slv_pd_n = 1;
    logic seek_done_i, rd_done_i, rd_no_retry_o, st_done_i, pd_o;
    dfv_kind_t fmt_kind_o;
    logic [15:0] fmt_cyl_o;
    logic [3:0] fmt_head_o;
    logic [8:0] rd_count_o;
    logic [39:0] fmt_seen = 0;
    logic [15:0] tbl [6] = '{16'h0100, 16'h0280, 16'h0500, 16'h0340, 16'h0420, 16'h0110};
    int miscompares = 0, tests_run = 0, cyc = 0, n_seek = 0, n_rd = 0;
    always #5 clk_i = ~clk_i;
    dfv_cmd_core #(.DIAG_WAIT(50)) dut_u (.clk_i, .arst_n_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .intrq_o,
        .master_cfg_i(1'b1), .slave_fitted_i(1'b1),
        .passed_diag_line_i((line_oe_n | pd_o) & slv_pd_n),
        .passed_diag_line_o(pd_o), .passed_diag_line_oe_n_o(line_oe_n), .fmt_valid_o,
        .fmt_ready_i, .fmt_sec_id_o, .fmt_kind_o, .fmt_cyl_o, .fmt_head_o, .fmt_fill_o,
        .cache_part_chg_i, .cache_act_hit_i, .cache_cyl_valid_i, .cache_oth_hit_i,
        .seek_req_o, .seek_done_i, .rd_req_o, .rd_count_o, .rd_no_retry_o, .rd_done_i,
        .rd_err_i, .st_start_o(st_go), .st_done_i, .st_code_i(8'h01));
    dfv_far_model far_u (.clk_i, .fmt_valid_i(fmt_valid_o), .seek_req_i(seek_req_o),
        .rd_req_i(rd_req_o), .st_start_i(st_go), .fmt_ready_o(fmt_ready_i),
        .seek_done_o(seek_done_i), .rd_done_o(rd_done_i), .st_done_o(st_done_i));
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        n_rd += rd_req_o;
        n_seek += seek_req_o;
        if (fmt_valid_o & fmt_ready_i)
        begin
            fmt_seen <= {fmt_seen[29:0], fmt_kind_o, fmt_sec_id_o};
            chk("fmt_place", {8'h00, 20'h01023}, {fmt_fill_o, fmt_cyl_o, fmt_head_o});
        end
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] hs;
        @(posedge clk_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do
        begin
            @(negedge clk_i);
            hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
            rr = s_axi_bresp;
            @(posedge clk_i);
            if (hs[2]) s_axi_awvalid <= 1'b0;
            if (hs[1]) s_axi_wvalid <= 1'b0;
        end while (!hs[0]);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic [1:0] hs;
        @(posedge clk_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do
        begin
            @(negedge clk_i);
            hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
            {rv, rr} = {s_axi_rdata, s_axi_rresp};
            @(posedge clk_i);
            if (hs[1]) s_axi_arvalid <= 1'b0;
        end while (!hs[0]);
        s_axi_rready <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op);
        wr(OFS_CMD, {24'h0, op});
        while (intrq_o !== 1'b1) @(negedge clk_i);
    endtask
    task automatic t_format;
        rd(OFS_ERROR);
        chk("err_rst", RST_ERR, rv);
        rd(8'hFC);
        chk("unmapped", RESP_DECERR, rr);
        wr(8'hFC, 32'h0);
        chk("wr_unmapped", RESP_DECERR, rr);
        wr(OFS_SDH, 32'h23);
        wr(OFS_SECCNT, 32'h4);
        wr(OFS_CYL_LO, 32'h2);
        wr(OFS_CYL_HI, 32'h1);
        wr(OFS_TBLIDX, 32'h0);
        for (int i = 0; i < 256; i++) wr(OFS_TBLDAT, i < 6 ? tbl[i] : 32'h0);
        cmd(OP_FORMAT);
        chk("fmt_seq", {FK_GOOD, 8'd1, FK_BAD, 8'd2, FK_ASSIGN, 8'd3, FK_UNASSIGN, 8'd4},
            fmt_seen);
        wr(OFS_SDH, 32'h03);
        cmd(OP_FORMAT);
        rd(OFS_ERROR);
        chk("bad_size", ERR_ABORT, rv);
    endtask
    task automatic vfy(input logic [4:0] c, input logic [7:0] op, input int s, input int r);
        @(posedge clk_i);
        {cache_part_chg_i, cache_act_hit_i, cache_cyl_valid_i, cache_oth_hit_i, rd_err_i} <= c;
        {n_seek, n_rd} = 0;
        cmd(op);
        chk("seeks", s, n_seek);
        chk("reads", r, n_rd);
    endtask
    task automatic t_verify;
        wr(OFS_SECCNT, 32'h0);
        vfy(5'b00100, OP_VERIFY, 0, 1);
        chk("rd_count", 9'h100, rd_count_o);
        vfy(5'b00000, 8'h41, 1, 1);
        chk("no_retry", 1'b1, rd_no_retry_o);
        vfy(5'b00010, OP_VERIFY, 0, 0);
        vfy(5'b01100, OP_VERIFY, 0, 0);
        vfy(5'b10001, OP_VERIFY, 1, 1);
        rd(OFS_ERROR);
        chk("rd_err", ERR_UNC, rv);
    endtask
    task automatic t_diag;
        wr(OFS_SDH, 32'h33);
        cmd(OP_DIAG);
        rd(OFS_ERROR);
        chk("diag_code", 8'h81, rv);
        rd(OFS_SDH);
        chk("drv_bit", 1'b0, rv[SDH_DRV_BIT]);
        chk("line_free", 1'b1, line_oe_n);
        slv_pd_n <= 1'b0;
        cmd(OP_DIAG);
        rd(OFS_ERROR);
        chk("diag_pass", DG_OK, rv);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_format;
        t_verify;
        t_diag;
        end_sim;
    end
endmodule
